// file: logic/ipc_pad_ctrl.sv
// Pad control registers for the four bus-capable pins, on APB.
// Notes on behaviour
// - A set edge-rate select bit applies bus slew limiting, turns off the ordinary limiter and ignores the GPIO edge-rate bit; clear, the GPIO bit rules.
// - Bias field 00 uses the GPIO weak pull-up bit, 01 gives twice and 10 ten times the standard current, 11 is reserved.
// - Level field 11 picks the 1.35 V threshold, 10 the 2.1 V one, 01 bus thresholds and 00 the GPIO level bits.
// - Bit 7 and bits 3 to 2 read as zero and ignore writes.
// - The implemented fields are read/write and clear to zero on every reset.
// - There are four identical pad control registers for pins B1, B2, C3 and C4.
// - Peripherals reading a pad take the Schmitt input when its register enables it.
// - In debug mode, reads of port B pins 6 and 7 return one.
// - Port E bit 3 is read-only and reads one while master clear is enabled.
// - With master clear enabled the port E pin 3 pull-up is forced on, its stored enable untouched.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module ipc_pad_ctrl import ipc_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_mode,
    input wire logic master_clear_enable,
    input wire logic port_e_pin3_bias_en,
    input wire logic [3:0] gpio_edge_rate_bit,
    input wire logic [3:0] gpio_weak_bias_bit,
    input wire logic [3:0] gpio_input_level_bit,
    input wire logic port_b_pin6,
    input wire logic port_b_pin7,
    input wire logic port_e_pin3,
    input wire logic [3:0] pad_schmitt_input,
    input wire logic [3:0] pad_std_input,
    output logic [3:0] bus_slew_en,
    output logic [3:0] std_slew_en,
    output logic [7:0] pull_mode,
    output logic [11:0] thresh_mode,
    output logic [3:0] periph_in,
    output logic port_e_pin3_pullup
);
    logic [7:0] pad_ctrl_reg [NUM_PADS];
    logic [10:0] pins_raw;
    logic [10:0] pins_sync;
    logic b6_sync;
    logic b7_sync;
    logic e3_sync;
    logic [3:0] st_sync;
    logic [3:0] std_sync;
    logic setup;
    logic access;
    logic wr_en;
    logic [3:0] pad_hit;
    logic port_hit;
    logic [7:0] port_word;
    logic [31:0] next_rdata;
    logic next_err;

    // Pin levels come from outside the clock domain, so all of them pass
    // a two-stage synchroniser before any logic looks at them.
    assign pins_raw = {pad_std_input, pad_schmitt_input, port_e_pin3,
        port_b_pin7, port_b_pin6};

    ipc_sync2 #(
        .W(11)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .d(pins_raw),
        .q(pins_sync)
    );

    assign b6_sync = pins_sync[0];
    assign b7_sync = pins_sync[1];
    assign e3_sync = pins_sync[2];
    assign st_sync = pins_sync[6:3];
    assign std_sync = pins_sync[10:7];

    // Bus phases. The slave never inserts wait states.
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign wr_en = access && pwrite && pstrb[0];

    // Address decode, one hit line per pad register.
    always_comb begin
        pad_hit = 4'h0;
        pad_hit[0] = (paddr == OFS_PAD_B1);
        pad_hit[1] = (paddr == OFS_PAD_B2);
        pad_hit[2] = (paddr == OFS_PAD_C3);
        pad_hit[3] = (paddr == OFS_PAD_C4);
    end

    assign port_hit = (paddr == OFS_PORT_RD);

    // Pad registers. Unimplemented bits are masked at the write, so they
    // can never hold a one and always read back as zero.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_PADS; i++) begin
                pad_ctrl_reg[i] <= PAD_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_PADS; i++) begin
                if (wr_en && pad_hit[i]) begin
                    pad_ctrl_reg[i] <= pwdata[7:0] & PAD_IMPL_MASK;
                end
            end
        end
    end

    // Port read-back word. Debug mode pins the two port B bits high and
    // an enabled master clear pins port E bit 3 high.
    always_comb begin
        port_word = 8'h00;
        port_word[RD_B6] = b6_sync | debug_mode;
        port_word[RD_B7] = b7_sync | debug_mode;
        port_word[RD_E3] = e3_sync | master_clear_enable;
    end

    // Read data mux. Unmapped offsets answer zero with an error flag.
    // The read-back word has no write path, so writes there are dropped
    // quietly rather than flagged.
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (port_hit) begin
            next_rdata[7:0] = port_word;
        end else if (pad_hit != 4'h0) begin
            for (int i = 0; i < NUM_PADS; i++) begin
                if (pad_hit[i]) begin
                    next_rdata[7:0] = pad_ctrl_reg[i];
                end
            end
        end else begin
            next_err = 1'b1;
        end
    end

    // Read data and error are captured in the setup cycle so that the
    // outputs come from flops and stand still through the access cycle.
    // The cost is that a read sees pin state one clock older.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= next_err;
        end
    end

    // One decoder per pad, all of the same layout.
    ipc_pad_if pad_if [NUM_PADS] ();

    for (genvar g = 0; g < NUM_PADS; g++) begin : g_pad
        // Decoded selections follow the register flops directly.
        assign pad_if[g].cfg = pad_ctrl_reg[g];
        assign pad_if[g].gpio_slew = gpio_edge_rate_bit[g];
        assign pad_if[g].gpio_bias = gpio_weak_bias_bit[g];
        assign pad_if[g].gpio_level = gpio_input_level_bit[g];
        assign pad_if[g].st_in = st_sync[g];
        assign pad_if[g].std_in = std_sync[g];

        ipc_pad_decode u_dec (
            .pad(pad_if[g])
        );

        assign bus_slew_en[g] = pad_if[g].bus_slew;
        assign std_slew_en[g] = pad_if[g].std_slew;
        assign pull_mode[2*g +: 2] = pad_if[g].pull;
        assign thresh_mode[3*g +: 3] = pad_if[g].thr;
        assign periph_in[g] = pad_if[g].periph_in;
    end

    // Master clear forces the pull-up without touching the stored
    // enable, which lives outside this block and is only read here.
    assign port_e_pin3_pullup = master_clear_enable |
        port_e_pin3_bias_en;

    // Checks on the pad decode, register file and read-back.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_slew_override: assert property (
        pad_ctrl_reg[0][SLEW_POS] |-> bus_slew_en[0] && !std_slew_en[0])
        else $error("bus slew set but ordinary limiter still active");

    chk_slew_gpio: assert property (
        !pad_ctrl_reg[1][SLEW_POS] |->
        !bus_slew_en[1] && std_slew_en[1] == gpio_edge_rate_bit[1])
        else $error("ordinary slew not following the gpio bit");

    chk_bias_scaled: assert property (
        pad_ctrl_reg[2][BIAS_LO +: 2] == BIAS_10X |->
        pull_mode[5:4] == PULL_10X)
        else $error("ten times pull-up not selected");

    chk_bias_gpio: assert property (
        pad_ctrl_reg[3][BIAS_LO +: 2] == BIAS_STD |->
        pull_mode[7:6] == (gpio_weak_bias_bit[3] ? PULL_WEAK : PULL_OFF))
        else $error("standard pull-up not following the gpio bit");

    chk_level_decode: assert property (
        pad_ctrl_reg[0][LEVEL_LO +: 2] == LEVEL_SMB3 |->
        thresh_mode[2:0] == THR_SMB3)
        else $error("1.35 V threshold not selected");

    chk_unimpl_zero: assert property (
        access && !pwrite && pad_hit != 4'h0 |->
        prdata[31:8] == 24'h0 && !prdata[7] && prdata[3:2] == 2'h0)
        else $error("unimplemented pad bits read as one");

    chk_write_lands: assert property (
        wr_en && pad_hit[2] |=>
        pad_ctrl_reg[2] == ($past(pwdata[7:0]) & PAD_IMPL_MASK) &&
        (thresh_mode[8:6] != THR_TTL || pad_ctrl_reg[2][1:0] == 2'h0))
        else $error("pad write not applied on the next clock");

    chk_reset_clear: assert property (
        $rose(reset_n) |-> pad_ctrl_reg[0] == PAD_RESET &&
        pad_ctrl_reg[1] == PAD_RESET && pad_ctrl_reg[2] == PAD_RESET &&
        pad_ctrl_reg[3] == PAD_RESET)
        else $error("pad registers not cleared by reset");

    chk_schmitt_route: assert property (
        pad_ctrl_reg[1][LEVEL_LO +: 2] != LEVEL_GPIO |->
        periph_in[1] == st_sync[1])
        else $error("peripheral not on the schmitt input");

    chk_debug_read: assert property (
        setup && !pwrite && port_hit && debug_mode |=>
        prdata[RD_B6] && prdata[RD_B7] && pslverr == 1'b0)
        else $error("debug mode read of port b pins not one");

    chk_mclr_read: assert property (
        setup && !pwrite && port_hit && master_clear_enable |=>
        prdata[RD_E3])
        else $error("port e bit 3 not one under master clear");

    chk_mclr_pull: assert property (
        master_clear_enable |-> port_e_pin3_pullup)
        else $error("master clear did not force the pull-up");

    chk_unmapped_err: assert property (
        setup && (pad_hit == 4'h0) && !port_hit |=>
        pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

    // Bus side: read data must stand through the access cycle, and the
    // read-back word must take writes quietly and show sampled pins.
    chk_read_stands: assert property (
        access |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved during the access cycle");

    chk_port_quiet: assert property (
        setup && pwrite && port_hit |=> !pslverr)
        else $error("write to the read-back word flagged an error");

    chk_port_plain: assert property (
        setup && !pwrite && port_hit && !debug_mode |=>
        prdata[RD_B6] == $past(b6_sync) && prdata[RD_B7] == $past(b7_sync))
        else $error("port b pins not read back as sampled");

    chk_e3_plain: assert property (
        setup && !pwrite && port_hit && !master_clear_enable |=>
        prdata[RD_E3] == $past(e3_sync) && prdata[31:3] == 29'h0)
        else $error("port e bit 3 not read back as sampled");

    chk_pull_stored: assert property (
        !master_clear_enable |-> port_e_pin3_pullup == port_e_pin3_bias_en)
        else $error("pull-up not following the stored enable");

    // The same checks on every pad, so that a fault confined to one
    // pad cannot hide behind checks that watch another, except in the
    // standard pull-up, 1.35 V threshold and write checks, which watch pads 3, 0 and 2 alone.
    for (genvar g = 0; g < NUM_PADS; g++) begin : g_chk
        chk_reg_hold: assert property (
            !(wr_en && pad_hit[g]) |=> $stable(pad_ctrl_reg[g]))
            else $error("pad register changed without a write");

        chk_reg_masked: assert property (
            (pad_ctrl_reg[g] & ~PAD_IMPL_MASK) == 8'h00)
            else $error("unimplemented pad bit holds a one");

        chk_slew_pair: assert property (
            bus_slew_en[g] == pad_ctrl_reg[g][SLEW_POS] &&
            std_slew_en[g] ==
            (!pad_ctrl_reg[g][SLEW_POS] && gpio_edge_rate_bit[g]))
            else $error("slew selection not following the register");

        chk_pull_2x: assert property (
            pad_ctrl_reg[g][BIAS_LO +: 2] == BIAS_2X |->
            pull_mode[2*g +: 2] == PULL_2X)
            else $error("twice pull-up not selected");

        chk_pull_10x: assert property (
            pad_ctrl_reg[g][BIAS_LO +: 2] == BIAS_10X |->
            pull_mode[2*g +: 2] == PULL_10X)
            else $error("ten times pull-up not selected on a pad");

        chk_level_smb2: assert property (
            pad_ctrl_reg[g][LEVEL_LO +: 2] == LEVEL_SMB2 |->
            thresh_mode[3*g +: 3] == THR_SMB2)
            else $error("2.1 V threshold not selected");

        chk_level_bus: assert property (
            pad_ctrl_reg[g][LEVEL_LO +: 2] == LEVEL_BUS |->
            thresh_mode[3*g +: 3] == THR_BUS)
            else $error("bus threshold not selected");

        chk_level_gpio: assert property (
            pad_ctrl_reg[g][LEVEL_LO +: 2] == LEVEL_GPIO |->
            thresh_mode[3*g +: 3] ==
            (gpio_input_level_bit[g] ? THR_SCHMITT : THR_TTL))
            else $error("threshold not following the gpio level bit");

        chk_route_gpio: assert property (
            pad_ctrl_reg[g][LEVEL_LO +: 2] == LEVEL_GPIO |->
            periph_in[g] == std_sync[g])
            else $error("peripheral not on the ordinary input");

        chk_route_bus: assert property (
            pad_ctrl_reg[g][LEVEL_LO +: 2] != LEVEL_GPIO |->
            periph_in[g] == st_sync[g])
            else $error("peripheral not on the bus schmitt input");
    end
endmodule

// file: logic/ipc_pkg.sv
// Shared constants for the two-wire bus pad control block.
package ipc_pkg;
    // Bus and register map.
    localparam int ADDR_W = 12;
    localparam int NUM_PADS = 4;
    localparam logic [11:0] OFS_PAD_B1 = 12'h000;
    localparam logic [11:0] OFS_PAD_B2 = 12'h004;
    localparam logic [11:0] OFS_PAD_C3 = 12'h008;
    localparam logic [11:0] OFS_PAD_C4 = 12'h00c;
    localparam logic [11:0] OFS_PORT_RD = 12'h010;
    // Pad control field layout and reset value.
    localparam int SLEW_POS = 6;
    localparam int BIAS_LO = 4;
    localparam int LEVEL_LO = 0;
    localparam logic [7:0] PAD_IMPL_MASK = 8'h73;
    localparam logic [7:0] PAD_RESET = 8'h00;
    // Bias current field codes.
    localparam logic [1:0] BIAS_STD = 2'h0;
    localparam logic [1:0] BIAS_2X = 2'h1;
    localparam logic [1:0] BIAS_10X = 2'h2;
    // Input level field codes.
    localparam logic [1:0] LEVEL_GPIO = 2'h0;
    localparam logic [1:0] LEVEL_BUS = 2'h1;
    localparam logic [1:0] LEVEL_SMB2 = 2'h2;
    localparam logic [1:0] LEVEL_SMB3 = 2'h3;
    // Pull-up drive codes sent to the pad.
    localparam logic [1:0] PULL_OFF = 2'h0;
    localparam logic [1:0] PULL_WEAK = 2'h1;
    localparam logic [1:0] PULL_2X = 2'h2;
    localparam logic [1:0] PULL_10X = 2'h3;
    // Input threshold codes sent to the pad.
    localparam logic [2:0] THR_TTL = 3'h0;
    localparam logic [2:0] THR_SCHMITT = 3'h1;
    localparam logic [2:0] THR_BUS = 3'h2;
    localparam logic [2:0] THR_SMB2 = 3'h3;
    localparam logic [2:0] THR_SMB3 = 3'h4;
    // Bit positions in the port read-back register.
    localparam int RD_B6 = 0;
    localparam int RD_B7 = 1;
    localparam int RD_E3 = 2;
endpackage

// file: logic/ipc_pad_if.sv
// Bundle between the register file and one pad decoder.
`timescale 1ns/100ps
interface ipc_pad_if;
    logic [7:0] cfg;
    logic gpio_slew;
    logic gpio_bias;
    logic gpio_level;
    logic st_in;
    logic std_in;
    logic bus_slew;
    logic std_slew;
    logic [1:0] pull;
    logic [2:0] thr;
    logic periph_in;
    modport ctl (output cfg, gpio_slew, gpio_bias, gpio_level, st_in,
        std_in, input bus_slew, std_slew, pull, thr, periph_in);
    modport dec (input cfg, gpio_slew, gpio_bias, gpio_level, st_in,
        std_in, output bus_slew, std_slew, pull, thr, periph_in);
endinterface

// file: logic/ipc_sync2.sv
// Two-stage synchroniser for pin levels.
`timescale 1ns/100ps
module ipc_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: logic/ipc_pad_decode.sv
// Decodes one pad control byte into pad drive and input selections.
`timescale 1ns/100ps
module ipc_pad_decode import ipc_pkg::*; (
    ipc_pad_if.dec pad
);
    logic [1:0] bias_current_sel;
    logic [1:0] input_level_sel;

    assign bias_current_sel = pad.cfg[BIAS_LO +: 2];
    assign input_level_sel = pad.cfg[LEVEL_LO +: 2];

    // Bus slew limiting replaces the ordinary limiter outright.
    always_comb begin
        pad.bus_slew = pad.cfg[SLEW_POS];
        pad.std_slew = pad.cfg[SLEW_POS] ? 1'b0 : pad.gpio_slew;
    end

    // The reserved code falls back to the ordinary pull-up path.
    always_comb begin
        unique case (bias_current_sel)
            BIAS_2X: pad.pull = PULL_2X;
            BIAS_10X: pad.pull = PULL_10X;
            default: pad.pull = pad.gpio_bias ? PULL_WEAK : PULL_OFF;
        endcase
    end

    // Bus thresholds override the ordinary level select.
    always_comb begin
        unique case (input_level_sel)
            LEVEL_SMB3: pad.thr = THR_SMB3;
            LEVEL_SMB2: pad.thr = THR_SMB2;
            LEVEL_BUS: pad.thr = THR_BUS;
            default: pad.thr = pad.gpio_level ? THR_SCHMITT : THR_TTL;
        endcase
    end

    // Peripherals see the bus Schmitt input once it is enabled.
    assign pad.periph_in = (input_level_sel != LEVEL_GPIO) ?
        pad.st_in : pad.std_in;
endmodule

// file: tb/ipc_bus_dev.sv
// Model of the bus devices sharing the four pads, seen by both receivers.
`timescale 1ns/100ps
module ipc_bus_dev (
    input wire logic [3:0] line_lvl,
    output logic [3:0] pad_schmitt_input,
    output logic [3:0] pad_std_input
);
    // A slow bus edge sits between the two thresholds, so the receivers
    // disagree; this makes a wrong receiver choice visible.
    assign pad_schmitt_input = line_lvl;
    assign pad_std_input = ~line_lvl;
endmodule

// file: tb/i2c_pad_control_tb.sv
// Self-checking bench for the two-wire bus pad control block.
`timescale 1ns/100ps
module i2c_pad_control_tb;
    import ipc_pkg::*;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, d;
    logic [3:0] pstrb = 4'hf, slr = 0, wpu = 0, inl = 0, lvl = 0;
    logic [3:0] bse, sse, pin, sch, std_lvl;
    logic [7:0] pull;
    logic [11:0] thr;
    logic dbg = 0, mce = 0, wpue = 0, b6 = 0, b7 = 0, e3 = 0;
    logic pready, pslverr, err, e3pu;
    logic [7:0] cfg [4];
    int bad_count = 0, total_checks = 0, cycles = 0, seed = 71, g;

    // Half-period toggle gives the 25 MHz system clock.
    always #20 mclk = ~mclk;

    ipc_bus_dev u_ipc_bus_dev (.line_lvl(lvl), .pad_schmitt_input(sch),
        .pad_std_input(std_lvl));

    ipc_pad_ctrl u_ipc_pad_ctrl (.mclk(mclk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debug_mode(dbg), .master_clear_enable(mce),
        .port_e_pin3_bias_en(wpue), .gpio_edge_rate_bit(slr),
        .gpio_weak_bias_bit(wpu), .gpio_input_level_bit(inl),
        .port_b_pin6(b6), .port_b_pin7(b7), .port_e_pin3(e3),
        .pad_schmitt_input(sch), .pad_std_input(std_lvl), .bus_slew_en(bse),
        .std_slew_en(sse), .pull_mode(pull), .thresh_mode(thr),
        .periph_in(pin), .port_e_pin3_pullup(e3pu));

    // Expected pull-up drive for one pad; the reserved code falls back.
    function automatic logic [1:0] exp_pull(logic [7:0] c, logic w);
        case (c[5:4])
            BIAS_2X: return PULL_2X;
            BIAS_10X: return PULL_10X;
            default: return w ? PULL_WEAK : PULL_OFF;
        endcase
    endfunction

    // Expected input threshold for one pad.
    function automatic logic [2:0] exp_thr(logic [7:0] c, logic l);
        case (c[1:0])
            LEVEL_SMB3: return THR_SMB3;
            LEVEL_SMB2: return THR_SMB2;
            LEVEL_BUS: return THR_BUS;
            default: return l ? THR_SCHMITT : THR_TTL;
        endcase
    endfunction

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic check_regs;
        for (int k = 0; k < NUM_PADS; k++) begin
            apb(0, ADDR_W'(k * 4), 32'h0);
            chk("pad_ctrl", {24'h0, cfg[k]}, rd);
        end
    endtask

    // Decoded pad outputs against the stored bytes and GPIO settings.
    task automatic check_pads;
        for (int k = 0; k < NUM_PADS; k++) begin
            chk("bus_slew_en", cfg[k][6], bse[k]);
            chk("std_slew_en", !cfg[k][6] && slr[k], sse[k]);
            chk("pull_mode", exp_pull(cfg[k], wpu[k]), pull[2*k+:2]);
            chk("thresh_mode", exp_thr(cfg[k], inl[k]), thr[3*k+:3]);
            chk("periph_in", cfg[k][1:0] != 0 ? lvl[k] : !lvl[k], pin[k]);
        end
    endtask

    // A hang is cut short well past the expected run length.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            $display("ERROR cycle_limit expected below %0d seen %0d", 5000,
                cycles);
            bad_count++;
            complete_run;
        end
    end

    initial begin
        for (int k = 0; k < NUM_PADS; k++) cfg[k] = PAD_RESET;
        repeat (10) @(posedge mclk);
        reset_n <= 1;
        check_regs;
        @(negedge mclk);
        check_pads;
        // Random writes; every bias and level code is forced in turn.
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            d[5:4] = i[1:0];
            d[1:0] = i[3:2];
            g = {$random(seed)} % 4;
            @(posedge mclk);
            slr <= $random(seed);
            wpu <= $random(seed);
            inl <= $random(seed);
            lvl <= $random(seed);
            pstrb <= (i == 5) ? 4'he : 4'hf;
            apb(1, ADDR_W'(g * 4), d);
            if (i != 5) cfg[g] = d[7:0] & PAD_IMPL_MASK;
            @(negedge mclk);
            check_pads;
        end
        // Corner bytes: all ones (reserved bias, top level code), then a
        // mixed pattern with ten times pull-up and bus thresholds.
        for (int k = 0; k < 8; k++) begin
            d = k[0] ? 32'h0000_00a1 : 32'hffff_ffff;
            apb(1, ADDR_W'((k / 2) * 4), d);
            cfg[k / 2] = d[7:0] & PAD_IMPL_MASK;
            @(negedge mclk);
            check_pads;
        end
        check_regs;
        // Unmapped place: error flag, zero data, write ignored.
        apb(1, 12'h020, 32'hffff_ffff);
        chk("pslverr", 1, err);
        apb(0, 12'h020, 32'h0);
        chk("pslverr", 1, err);
        chk("prdata", 0, rd);
        check_regs;
        // Port read-back overrides for debug mode and master clear.
        for (int k = 0; k < 16; k++) begin
            @(posedge mclk);
            {dbg, mce, wpue} <= k[2:0];
            {b6, b7, e3} <= {3{k[3]}};
            repeat (3) @(posedge mclk);
            apb(1, OFS_PORT_RD, 32'hffff_ffff);
            chk("pslverr", 0, err);
            apb(0, OFS_PORT_RD, 32'h0);
            chk("port_rd", {29'h0, mce | k[3], {2{dbg | k[3]}}}, rd);
            chk("pullup", mce | wpue, e3pu);
        end
        // Reset in mid-run clears written values again.
        apb(1, OFS_PAD_C3, 32'h0000_00ff);
        apb(0, OFS_PAD_C3, 32'h0);
        chk("pad_ctrl", {24'h0, PAD_IMPL_MASK}, rd);
        @(posedge mclk);
        reset_n <= 0;
        repeat (2) @(posedge mclk);
        reset_n <= 1;
        for (int k = 0; k < NUM_PADS; k++) cfg[k] = PAD_RESET;
        check_regs;
        complete_run;
    end
endmodule
